// ==== rtl/fpx_consts.svh ====
// timing constants and sizes of the front-panel crosspoint controller
`ifndef FPX_CONSTS_SVH
`define FPX_CONSTS_SVH
`define FPX_CLK_PERIOD_NS 10
`define FPX_CYC_PER_MS (1000000 / `FPX_CLK_PERIOD_NS)
`define FPX_LOCK_HOLD_MS 3000
`define FPX_MODE_HOLD_MS 2000
`define FPX_IDLE_MS 3000
`define FPX_BLINK_MS 250
`define FPX_DEBOUNCE_MS 10
`define FPX_N_SRC 6
`define FPX_N_DST 2
`endif

// ==== rtl/fpx_pkg.sv ====
// types shared by the front-panel crosspoint controller
package fpx_pkg;
  // power-up sequencing states
  typedef enum logic [1:0] {
    FPX_BOOT_TEST = 2'b00,
    FPX_BOOT_LOAD = 2'b01,
    FPX_BOOT_RUN = 2'b10,
    FPX_BOOT_FAIL = 2'b11
  } fpx_boot_t;
endpackage

// ==== rtl/fpx_btn_if.sv ====
// debounced button levels and edge pulses between debouncer and panel logic
`timescale 1ns/100ps
interface fpx_btn_if #(parameter int W = 10);
  logic [W-1:0] lvl;
  logic [W-1:0] press;
  logic [W-1:0] rel;
  modport drv (output lvl, output press, output rel);
  modport use_side (input lvl, input press, input rel);
endinterface

// ==== rtl/fpx_debounce.sv ====
// shared-tick button debouncer producing levels and press/release pulses
`timescale 1ns/100ps
module fpx_debounce #(
  parameter int W = 10,
  parameter int DB_CYC = 1000000
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic [W-1:0] i_raw, // raw button levels, high = pressed
  fpx_btn_if.drv bus // debounced outputs
);
  logic [31:0] tick_cnt_r;
  logic tick;
  logic [W-1:0] samp_r;
  logic [W-1:0] lvl_r;
  logic [W-1:0] lvl_nxt;

  // ----------------------------------------
  // sample tick
  // ----------------------------------------
  // one shared counter keeps area small; every button sees the same window
  assign tick = (tick_cnt_r == 32'(DB_CYC - 1));
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_r <= 32'h0;
    end else if (tick) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  // accept a level only after two agreeing samples one tick apart
  assign lvl_nxt = tick ? ((i_raw & samp_r) | (lvl_r & (i_raw | samp_r))) : lvl_r;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      samp_r <= '0;
      lvl_r <= '0;
      bus.lvl <= '0;
      bus.press <= '0;
      bus.rel <= '0;
    end else begin
      if (tick) begin
        samp_r <= i_raw;
      end
      lvl_r <= lvl_nxt;
      bus.lvl <= lvl_nxt;
      bus.press <= lvl_nxt & ~lvl_r;
      bus.rel <= ~lvl_nxt & lvl_r;
    end
  end
endmodule

// ==== rtl/fpx_panel.sv ====
// front-panel crosspoint controller: buttons, lamps, modes, boot restore
`timescale 1ns/100ps
`include "fpx_consts.svh"
module fpx_panel #(
  parameter int N_SRC = `FPX_N_SRC,
  parameter int N_DST = `FPX_N_DST,
  parameter int LOCK_HOLD_CYC = `FPX_LOCK_HOLD_MS * `FPX_CYC_PER_MS,
  parameter int MODE_HOLD_CYC = `FPX_MODE_HOLD_MS * `FPX_CYC_PER_MS,
  parameter int IDLE_CYC = `FPX_IDLE_MS * `FPX_CYC_PER_MS,
  parameter int BLINK_CYC = `FPX_BLINK_MS * `FPX_CYC_PER_MS,
  parameter int DB_CYC = `FPX_DEBOUNCE_MS * `FPX_CYC_PER_MS,
  localparam int SW = (N_SRC > 1) ? $clog2(N_SRC) : 1,
  localparam int DW = (N_DST > 1) ? $clog2(N_DST) : 1,
  localparam int NVW = N_DST * (SW + 1) + 2
) (
  input wire logic i_sys_clk, // system clock, 100 MHz
  input wire logic i_rst_n, // async reset, active low
  input wire logic [N_SRC-1:0] i_src_btn, // source buttons, high = pressed
  input wire logic [N_DST-1:0] i_dst_btn, // destination buttons
  input wire logic i_take_btn, // take button
  input wire logic i_lock_btn, // panel lock button
  input wire logic [N_DST-1:0] i_dst_lock, // destination lock flags
  input wire logic i_rem_vld, // remote crosspoint command strobe
  input wire logic [DW-1:0] i_rem_dst, // remote destination index
  input wire logic [SW-1:0] i_rem_src, // remote source index
  input wire logic i_rem_mute, // remote mute request
  input wire logic i_selftest_done, // self-test finished
  input wire logic i_hw_fail, // self-test found a fault
  input wire logic i_nv_rd_vld, // stored settings valid
  input wire logic [NVW-1:0] i_nv_rd_data, // stored settings image
  output logic o_nv_rd_req, // request stored settings
  output logic o_nv_wr_en, // store new settings image
  output logic [NVW-1:0] o_nv_wr_data, // settings image to store
  output fpx_pkg::fpx_boot_t o_boot_state, // power-up state
  output logic o_booting, // booting message on
  output logic o_error, // error message on
  output logic [N_SRC-1:0] o_src_lamp, // source lamps
  output logic [N_DST-1:0] o_dst_lamp, // destination lamps
  output logic o_take_lamp, // take lamp, green
  output logic o_lock_lamp, // lock lamp, red
  output logic [N_DST-1:0][SW-1:0] o_xp_src, // connected source per destination
  output logic [N_DST-1:0] o_xp_mute // destination muted
);
  import fpx_pkg::*;
  localparam int NB = N_SRC + N_DST + 2;

  fpx_btn_if #(.W(NB)) btn ();
  fpx_boot_t boot_r;
  logic run;
  logic act;
  logic panel_lock_r;
  logic immediate_r;
  logic [31:0] lock_cnt_r;
  logic lock_fired_r;
  logic [31:0] mode_cnt_r;
  logic mode_fired_r;
  logic [31:0] idle_cnt_r;
  logic [31:0] blink_cnt_r;
  logic blink_r;
  logic idle_exp;
  logic [N_SRC-1:0] src_rel;
  logic [N_DST-1:0] dst_rel;
  logic any_press;
  logic take_short;
  logic sel_vld_r;
  logic [SW-1:0] sel_src_r;
  logic [N_DST-1:0] presel_r;
  logic view_vld_r;
  logic [DW-1:0] view_dst_r;
  logic commit;
  logic imm_sw;
  logic [SW-1:0] src_idx;
  logic [DW-1:0] dst_idx;
  logic [N_DST-1:0][SW-1:0] xp_src_r;
  logic [N_DST-1:0][SW-1:0] xp_src_nxt;
  logic [N_DST-1:0] xp_mute_r;
  logic [N_DST-1:0] xp_mute_nxt;
  logic [N_SRC-1:0] src_lamp_nxt;
  logic [N_DST-1:0] dst_lamp_nxt;

  // lowest set bit of a button vector
  function automatic logic [7:0] first_idx(input logic [15:0] v);
    logic [7:0] idx;
    idx = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        idx = 8'(i);
      end
    end
    return idx;
  endfunction

  // settings image: lock, mode, mutes, sources
  function automatic logic [NVW-1:0] pack(input logic lk, input logic md,
      input logic [N_DST-1:0] mu, input logic [N_DST-1:0][SW-1:0] sr);
    return {lk, md, mu, sr};
  endfunction

  // widen per-destination flags so they cover each destination's source field
  function automatic logic [N_DST-1:0][SW-1:0] lock_span(input logic [N_DST-1:0] m);
    logic [N_DST-1:0][SW-1:0] s;
    s = '0;
    for (int d = 0; d < N_DST; d++) begin
      s[d] = {SW{m[d]}};
    end
    return s;
  endfunction

  // ----------------------------------------
  // buttons
  // ----------------------------------------
  fpx_debounce #(.W(NB), .DB_CYC(DB_CYC)) u_db (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_raw({i_lock_btn, i_take_btn, i_dst_btn, i_src_btn}),
    .bus(btn.drv)
  );

  // actions are taken on release; buttons other than lock count only when unlocked and running
  assign run = (boot_r == FPX_BOOT_RUN);
  assign act = run && !panel_lock_r;
  assign src_rel = act ? btn.rel[N_SRC-1:0] : '0;
  assign dst_rel = act ? btn.rel[N_SRC+N_DST-1:N_SRC] : '0;
  assign any_press = act && (|btn.press[N_SRC+N_DST:0]);
  assign take_short = act && btn.rel[N_SRC+N_DST] && !mode_fired_r;
  assign src_idx = SW'(first_idx(16'(src_rel)));
  assign dst_idx = DW'(first_idx(16'(dst_rel)));

  // ----------------------------------------
  // power-up sequencing
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      boot_r <= FPX_BOOT_TEST;
      o_nv_rd_req <= 1'b0;
    end else begin
      o_nv_rd_req <= 1'b0;
      case (boot_r)
        FPX_BOOT_TEST: begin
          if (i_selftest_done && i_hw_fail) begin
            boot_r <= FPX_BOOT_FAIL;
          end else if (i_selftest_done) begin
            boot_r <= FPX_BOOT_LOAD;
            o_nv_rd_req <= 1'b1;
          end
        end
        FPX_BOOT_LOAD: begin
          if (i_nv_rd_vld) begin
            boot_r <= FPX_BOOT_RUN;
          end
        end
        FPX_BOOT_RUN: boot_r <= FPX_BOOT_RUN;
        FPX_BOOT_FAIL: boot_r <= FPX_BOOT_FAIL;
        default: boot_r <= FPX_BOOT_FAIL;
      endcase
    end
  end

  // ----------------------------------------
  // lock and mode holds
  // ----------------------------------------
  // lock hold is watched even while locked, otherwise nothing could unlock
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lock_cnt_r <= 32'h0;
      lock_fired_r <= 1'b0;
      panel_lock_r <= 1'b0;
    end else if (boot_r == FPX_BOOT_LOAD && i_nv_rd_vld) begin
      panel_lock_r <= i_nv_rd_data[NVW-1];
    end else if (!run || !btn.lvl[NB-1]) begin
      lock_cnt_r <= 32'h0;
      lock_fired_r <= 1'b0;
    end else if (!lock_fired_r) begin
      if (lock_cnt_r == 32'(LOCK_HOLD_CYC - 1)) begin
        panel_lock_r <= !panel_lock_r;
        lock_fired_r <= 1'b1;
      end else begin
        lock_cnt_r <= lock_cnt_r + 32'h1;
      end
    end
  end

  // the fired flag survives to the release so that release is not a take
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_cnt_r <= 32'h0;
      mode_fired_r <= 1'b0;
      immediate_r <= 1'b0;
    end else if (boot_r == FPX_BOOT_LOAD && i_nv_rd_vld) begin
      immediate_r <= i_nv_rd_data[NVW-2];
    end else if (!act || !btn.lvl[N_SRC+N_DST]) begin
      mode_cnt_r <= 32'h0;
      mode_fired_r <= 1'b0;
    end else if (!mode_fired_r) begin
      if (mode_cnt_r == 32'(MODE_HOLD_CYC - 1)) begin
        immediate_r <= !immediate_r;
        mode_fired_r <= 1'b1;
      end else begin
        mode_cnt_r <= mode_cnt_r + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // idle timer and blink
  // ----------------------------------------
  assign idle_exp = (idle_cnt_r == 32'(IDLE_CYC - 1));
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_cnt_r <= 32'h0;
    end else if (any_press || !(sel_vld_r || view_vld_r) || idle_exp) begin
      idle_cnt_r <= 32'h0;
    end else begin
      idle_cnt_r <= idle_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blink_cnt_r <= 32'h0;
      blink_r <= 1'b0;
    end else if (blink_cnt_r == 32'(BLINK_CYC - 1)) begin
      blink_cnt_r <= 32'h0;
      blink_r <= !blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h1;
    end
  end

  // ----------------------------------------
  // pending selection and view
  // ----------------------------------------
  assign commit = take_short && !immediate_r && sel_vld_r;
  assign imm_sw = immediate_r && view_vld_r && (|src_rel) && !i_dst_lock[view_dst_r];

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_vld_r <= 1'b0;
      sel_src_r <= '0;
      presel_r <= '0;
      view_vld_r <= 1'b0;
      view_dst_r <= '0;
    end else if (!act || commit || mode_fired_r || (idle_exp && !immediate_r)) begin
      sel_vld_r <= 1'b0;
      presel_r <= '0;
      view_vld_r <= 1'b0;
    end else if (immediate_r) begin
      sel_vld_r <= 1'b0;
      presel_r <= '0;
      if (|dst_rel) begin
        view_vld_r <= 1'b1;
        view_dst_r <= dst_idx;
      end
    end else if (|src_rel) begin
      sel_vld_r <= 1'b1;
      sel_src_r <= src_idx;
      presel_r <= '0;
      view_vld_r <= 1'b0;
    end else if ((|dst_rel) && sel_vld_r) begin
      presel_r <= presel_r ^ (dst_rel & ~i_dst_lock);
    end else if (|dst_rel) begin
      view_vld_r <= 1'b1;
      view_dst_r <= dst_idx;
    end
  end

  // ----------------------------------------
  // crosspoint state
  // ----------------------------------------
  // remote commands follow panel changes, so they win on a shared destination
  always_comb begin
    xp_src_nxt = xp_src_r;
    xp_mute_nxt = xp_mute_r;
    if (commit) begin
      for (int d = 0; d < N_DST; d++) begin
        if (presel_r[d] && !i_dst_lock[d]) begin
          if (!xp_mute_r[d] && xp_src_r[d] == sel_src_r) begin
            xp_mute_nxt[d] = 1'b1;
          end else begin
            xp_src_nxt[d] = sel_src_r;
            xp_mute_nxt[d] = 1'b0;
          end
        end
      end
    end
    if (imm_sw) begin
      xp_src_nxt[view_dst_r] = src_idx;
      xp_mute_nxt[view_dst_r] = 1'b0;
    end
    if (run && i_rem_vld && 32'(i_rem_dst) < 32'(N_DST)) begin
      xp_src_nxt[i_rem_dst] = i_rem_src;
      xp_mute_nxt[i_rem_dst] = i_rem_mute;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xp_src_r <= '0;
      xp_mute_r <= '1;
    end else if (boot_r == FPX_BOOT_LOAD && i_nv_rd_vld) begin
      xp_src_r <= i_nv_rd_data[N_DST*SW-1:0];
      xp_mute_r <= i_nv_rd_data[NVW-3 -: N_DST];
    end else begin
      xp_src_r <= xp_src_nxt;
      xp_mute_r <= xp_mute_nxt;
    end
  end

  // each settled change is saved; the store is hidden from preset logic
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_nv_wr_en <= 1'b0;
      o_nv_wr_data <= '0;
    end else begin
      o_nv_wr_en <= run && (pack(panel_lock_r, immediate_r, xp_mute_r, xp_src_r) !=
          o_nv_wr_data);
      o_nv_wr_data <= pack(panel_lock_r, immediate_r, xp_mute_r, xp_src_r);
    end
  end

  // ----------------------------------------
  // lamps and outputs
  // ----------------------------------------
  always_comb begin
    src_lamp_nxt = '0;
    dst_lamp_nxt = '0;
    if (act && sel_vld_r) begin
      src_lamp_nxt[sel_src_r] = 1'b1;
      for (int d = 0; d < N_DST; d++) begin
        dst_lamp_nxt[d] = presel_r[d] ? blink_r :
            (!xp_mute_r[d] && xp_src_r[d] == sel_src_r);
      end
    end else if (act && view_vld_r) begin
      dst_lamp_nxt[view_dst_r] = 1'b1;
      if (!xp_mute_r[view_dst_r] && 32'(xp_src_r[view_dst_r]) < 32'(N_SRC)) begin
        src_lamp_nxt[xp_src_r[view_dst_r]] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_src_lamp <= '0;
      o_dst_lamp <= '0;
      o_take_lamp <= 1'b0;
      o_lock_lamp <= 1'b0;
      o_xp_src <= '0;
      o_xp_mute <= '1;
      o_boot_state <= FPX_BOOT_TEST;
      o_booting <= 1'b1;
      o_error <= 1'b0;
    end else begin
      o_src_lamp <= src_lamp_nxt;
      o_dst_lamp <= dst_lamp_nxt;
      o_take_lamp <= run && immediate_r;
      o_lock_lamp <= run && panel_lock_r;
      o_xp_src <= xp_src_r;
      o_xp_mute <= xp_mute_r;
      o_boot_state <= boot_r;
      o_booting <= (boot_r == FPX_BOOT_TEST) || (boot_r == FPX_BOOT_LOAD);
      o_error <= (boot_r == FPX_BOOT_FAIL);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  lock_block_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    run && panel_lock_r && !i_rem_vld |=> $stable(xp_src_r) && $stable(xp_mute_r)
      && o_src_lamp == '0 && o_dst_lamp == '0 && o_lock_lamp)
    else $error("panel lock did not block buttons");
  lock_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    run && btn.lvl[NB-1] && !lock_fired_r && lock_cnt_r == 32'(LOCK_HOLD_CYC - 1)
      |=> panel_lock_r != $past(panel_lock_r))
    else $error("lock hold did not toggle lock");
  remote_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    run && i_rem_vld && 32'(i_rem_dst) < 32'(N_DST)
      |=> xp_src_r[$past(i_rem_dst)] == $past(i_rem_src)
      && xp_mute_r[$past(i_rem_dst)] == $past(i_rem_mute))
    else $error("remote command not applied");
  take_lamp_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    run && $changed(immediate_r) |=> o_take_lamp == immediate_r)
    else $error("take lamp does not follow mode");
  mode_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    act && btn.lvl[N_SRC+N_DST] && !mode_fired_r && mode_cnt_r == 32'(MODE_HOLD_CYC - 1)
      |=> immediate_r != $past(immediate_r) ##1 !take_short)
    else $error("take hold did not toggle mode");
  defer_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    run && !immediate_r && !commit && !i_rem_vld |=> $stable(xp_src_r) && $stable(xp_mute_r))
    else $error("deferred mode changed crosspoint without take");
  idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    act && !immediate_r && idle_exp && sel_vld_r |=> !sel_vld_r && presel_r == '0
      ##1 o_src_lamp == '0 && o_dst_lamp == '0)
    else $error("idle timeout did not clear selection");
  imm_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    imm_sw && !i_rem_vld |=> xp_src_r[$past(view_dst_r)] == $past(src_idx)
      && !xp_mute_r[$past(view_dst_r)])
    else $error("immediate switch not applied");
  dst_lock_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    run && !i_rem_vld
      |=> ((xp_src_r ^ $past(xp_src_r)) & lock_span($past(i_dst_lock))) == '0
      && ((xp_mute_r ^ $past(xp_mute_r)) & $past(i_dst_lock)) == '0)
    else $error("locked destination changed from panel");
endmodule

// ==== verif/fpx_btn_model.sv ====
// front-panel button model: presses, holds and releases raw buttons
`timescale 1ns/100ps
module fpx_btn_model (
  input wire logic i_sys_clk, // system clock
  output logic [5:0] o_src_btn, // raw source buttons
  output logic [1:0] o_dst_btn, // raw destination buttons
  output logic o_take_btn, // raw take button
  output logic o_lock_btn // raw lock button
);
  logic [9:0] btn_r;
  // ----------------------------------------
  // button map: src 0..5, dst 6..7, take 8, lock 9
  // ----------------------------------------
  assign o_src_btn = btn_r[5:0];
  assign o_dst_btn = btn_r[7:6];
  assign o_take_btn = btn_r[8];
  assign o_lock_btn = btn_r[9];
  initial begin
    btn_r = 10'h000;
  end
  // one press; the tail waits out debounce plus the two-cycle action latency
  task automatic tap(input int idx, input int hold);
    @(posedge i_sys_clk);
    btn_r[idx] <= 1'b1;
    repeat (hold) @(posedge i_sys_clk);
    btn_r[idx] <= 1'b0;
    repeat (14) @(posedge i_sys_clk);
  endtask
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench of the front-panel crosspoint controller
`timescale 1ns/100ps
module tb_top;
  import fpx_pkg::*;
  localparam int LOCK = 40;
  localparam int MODE = 30;
  localparam int IDLE = 200;
  localparam int SHORT = 8;
  logic i_sys_clk, i_rst_n, i_rem_vld, i_rem_mute, i_selftest_done, i_hw_fail, i_nv_rd_vld;
  logic [5:0] src_btn;
  logic [1:0] dst_btn, i_dst_lock;
  logic take_btn, lock_btn, o_nv_rd_req, o_nv_wr_en, o_booting, o_error;
  logic o_take_lamp, o_lock_lamp;
  logic [0:0] i_rem_dst;
  logic [2:0] i_rem_src;
  logic [9:0] i_nv_rd_data, o_nv_wr_data;
  fpx_boot_t o_boot_state;
  logic [5:0] o_src_lamp;
  logic [1:0] o_dst_lamp, o_xp_mute;
  logic [1:0][2:0] o_xp_src;
  int err_count = 0;
  int n_checks = 0;
  // ----------------------------------------
  // clock, partner and design
  // ----------------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  fpx_btn_model u_pan (.i_sys_clk(i_sys_clk), .o_src_btn(src_btn), .o_dst_btn(dst_btn),
    .o_take_btn(take_btn), .o_lock_btn(lock_btn));
  fpx_panel #(.LOCK_HOLD_CYC(LOCK), .MODE_HOLD_CYC(MODE), .IDLE_CYC(IDLE), .BLINK_CYC(5),
    .DB_CYC(2)) u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_src_btn(src_btn),
    .i_dst_btn(dst_btn), .i_take_btn(take_btn), .i_lock_btn(lock_btn),
    .i_dst_lock(i_dst_lock), .i_rem_vld(i_rem_vld), .i_rem_dst(i_rem_dst),
    .i_rem_src(i_rem_src), .i_rem_mute(i_rem_mute), .i_selftest_done(i_selftest_done),
    .i_hw_fail(i_hw_fail), .i_nv_rd_vld(i_nv_rd_vld), .i_nv_rd_data(i_nv_rd_data),
    .o_nv_rd_req(o_nv_rd_req), .o_nv_wr_en(o_nv_wr_en), .o_nv_wr_data(o_nv_wr_data),
    .o_boot_state(o_boot_state), .o_booting(o_booting), .o_error(o_error),
    .o_src_lamp(o_src_lamp), .o_dst_lamp(o_dst_lamp), .o_take_lamp(o_take_lamp),
    .o_lock_lamp(o_lock_lamp), .o_xp_src(o_xp_src), .o_xp_mute(o_xp_mute));
  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one-cycle remote strobe, then room for the two-edge answer
  task automatic remote(input logic d, input logic [2:0] s, input logic m);
    @(posedge i_sys_clk);
    i_rem_vld <= 1'b1;
    i_rem_dst <= d;
    i_rem_src <= s;
    i_rem_mute <= m;
    @(posedge i_sys_clk);
    i_rem_vld <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_boot();
    int n;
    chk("booting", o_booting, 1'b1);
    chk("boot_state", o_boot_state, FPX_BOOT_TEST);
    i_selftest_done <= 1'b1;
    n = 0;
    while (o_nv_rd_req !== 1'b1 && n < 20) begin
      @(posedge i_sys_clk);
      n++;
    end
    chk("nv_rd_req", o_nv_rd_req, 1'b1);
    repeat (3) @(posedge i_sys_clk);
    i_nv_rd_vld <= 1'b1;
    i_nv_rd_data <= 10'h0C0;
    @(posedge i_sys_clk);
    i_nv_rd_vld <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    chk("boot_run", o_boot_state, FPX_BOOT_RUN);
    chk("boot_msg", {o_booting, o_error}, 2'b00);
    chk("restored_mute", o_xp_mute, 2'b11);
  endtask
  task automatic t_remote_store();
    int n;
    @(posedge i_sys_clk);
    i_rem_vld <= 1'b1;
    i_rem_dst <= 1'b1;
    i_rem_src <= 3'h4;
    i_rem_mute <= 1'b0;
    @(posedge i_sys_clk);
    i_rem_vld <= 1'b0;
    n = 0;
    while (o_nv_wr_en !== 1'b1 && n < 20) begin
      @(posedge i_sys_clk);
      n++;
    end
    chk("nv_wr_en", o_nv_wr_en, 1'b1);
    chk("nv_image", o_nv_wr_data, 10'h060);
    chk("rem_src1", o_xp_src[1], 3'h4);
    chk("rem_mute", o_xp_mute, 2'b01);
    repeat (4) @(posedge i_sys_clk);
  endtask
  task automatic t_take_commit();
    logic b;
    u_pan.tap(2, SHORT);
    chk("sel_src_lamp", o_src_lamp, 6'h04);
    chk("sel_dst_lamp", o_dst_lamp, 2'b00);
    u_pan.tap(6, SHORT);
    chk("pending_mute", o_xp_mute[0], 1'b1);
    b = o_dst_lamp[0];
    repeat (5) @(posedge i_sys_clk);
    chk("presel_blink", o_dst_lamp[0], !b);
    u_pan.tap(8, SHORT);
    chk("commit_src0", o_xp_src[0], 3'h2);
    chk("commit_mute", o_xp_mute, 2'b00);
    chk("take_lamp_def", o_take_lamp, 1'b0);
  endtask
  task automatic t_view_idle();
    u_pan.tap(4, SHORT);
    chk("view_src", {o_src_lamp, o_dst_lamp}, 8'h42);
    repeat (IDLE + 10) @(posedge i_sys_clk);
    chk("idle_dark", {o_src_lamp, o_dst_lamp}, 8'h00);
    u_pan.tap(7, SHORT);
    chk("view_dst", o_src_lamp, 6'h10);
    repeat (IDLE + 10) @(posedge i_sys_clk);
  endtask
  task automatic t_immediate();
    u_pan.tap(8, MODE + SHORT);
    chk("take_lamp_imm", o_take_lamp, 1'b1);
    chk("no_short_take", o_xp_src[1], 3'h4);
    u_pan.tap(7, SHORT);
    chk("imm_view", o_src_lamp, 6'h10);
    u_pan.tap(3, SHORT);
    chk("imm_switch", o_xp_src[1], 3'h3);
    i_dst_lock <= 2'b10;
    u_pan.tap(5, SHORT);
    chk("dst_locked", o_xp_src[1], 3'h3);
    i_dst_lock <= 2'b00;
  endtask
  task automatic t_panel_lock();
    u_pan.tap(9, LOCK + SHORT);
    chk("lock_lamp_on", o_lock_lamp, 1'b1);
    u_pan.tap(1, SHORT);
    chk("locked_ignore", o_xp_src[1], 3'h3);
    remote(1'b0, 3'h5, 1'b0);
    chk("locked_remote", o_xp_src[0], 3'h5);
    u_pan.tap(9, LOCK + SHORT);
    chk("lock_lamp_off", o_lock_lamp, 1'b0);
    u_pan.tap(7, SHORT);
    u_pan.tap(1, SHORT);
    chk("unlocked_switch", o_xp_src[1], 3'h1);
  endtask
  // mid-run reset, then a self-test that reports a hardware fault
  task automatic t_boot_fail();
    i_rst_n <= 1'b0;
    i_selftest_done <= 1'b0;
    i_hw_fail <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    chk("rst_lamps", {o_src_lamp, o_lock_lamp, o_take_lamp}, 8'h00);
    chk("rst_mute", o_xp_mute, 2'b11);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_selftest_done <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    chk("fail_state", {o_boot_state, o_booting, o_error, o_nv_rd_req}, 5'b11010);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    i_rst_n = 1'b0;
    i_rem_vld = 1'b0;
    i_rem_dst = 1'b0;
    i_rem_src = 3'h0;
    i_rem_mute = 1'b0;
    i_selftest_done = 1'b0;
    i_hw_fail = 1'b0;
    i_nv_rd_vld = 1'b0;
    i_nv_rd_data = 10'h000;
    i_dst_lock = 2'b00;
    repeat (16) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    t_boot();
    t_remote_store();
    t_take_commit();
    t_view_idle();
    t_immediate();
    t_panel_lock();
    t_boot_fail();
    report_and_stop();
  end
  // the scenarios need about 900 cycles; a hang is cut off well beyond
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    err_count++;
    report_and_stop();
  end
endmodule
